// file: src/hfu_core.sv
// Purpose: Hex float unit with four register banks and a Wishbone slave.
// Assumes: Bus inputs are synchronous to i_ref_clk.
// Notes:   Float registers have no reset; software loads them first.
//
// Summary of operation
// RULE_01: Four 64-bit float registers exist for each of four levels.
// RULE_02: Value is hex fraction times 16 to the exponent.
// RULE_03: Sign bit 0, characteristic bits 1-7, fraction to bit 31 or 63.
// RULE_04: Characteristic is exponent plus 64, range -64 to +63.
// RULE_05: Fractions are sign-magnitude; sign 1 means negative.
// RULE_06: Short operations leave the low 32 register bits unchanged; the code clears them on short convert-in.
// RULE_07: Short multiply writes a 64-bit product to the whole register.
// RULE_08: Short move from storage clears the low 32 register bits.
// RULE_09: Long operations use full 64-bit operands and results.
// RULE_10: Add and subtract keep one guard digit: seven short, fifteen long.
// RULE_11: Underflow or zero fraction forces a true zero result.
// RULE_12: Convert-in turns 16 or 32-bit integers into floats.
// RULE_13: Plain move from storage copies bits unaltered.
// RULE_14: Convert-out turns a register float into a binary integer.
// RULE_15: Normalize shifts one hex digit left and decrements per step.
// RULE_16: Multiply and effective subtraction results are normalized.
// RULE_17: True addition results are not normalized.
// RULE_18: Without the feature every instruction traps as invalid function; code gives spec check or privilege violation first.
// RULE_19: Privileged instruction in problem state raises privilege violation.
// RULE_20: Odd effective address raises specification check.
// RULE_21: Select 00, 01, 10 choose registers 0, 1, 2.
// RULE_22: Reset leaves the float registers untouched.
// RULE_23: Select 11 chooses register 3 within the active level bank.

`timescale 1ns/1ps
`default_nettype none

module hfu_core
	import hfu_pkg::*;
(
	// Clock and reset.
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	// Wishbone slave.
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack
);

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	logic [63:0] fpr_q [HFU_NLEVEL*HFU_NREG];
	hfu_ctrl_t   ctrl_q;
	hfu_trap_t   trap_q;
	hfu_state_t  state_q;
	logic [31:0] dhi_q, dlo_q, rhi_q, rlo_q;
	logic [63:0] w_q;
	logic [8:0]  exp_q;
	logic        sgn_q, norm_q, trunc_q, keep_q, done_q;
	logic [3:0]  dst_q;
	logic [31:0] lo_snap_q;

	// ----------------------------------------------------------------
	// Bus decode.
	// ----------------------------------------------------------------
	wire logic [31:0] wb_mask;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wb_mask[8*gi +: 8] = {8{i_wb_sel[gi]}};
		end
	endgenerate

	// A request is taken once, in the cycle before ack rises.
	wire logic      wb_hit  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire logic      wb_wr   = wb_hit & i_wb_we;
	wire logic      wr_ctrl = wb_wr & (i_wb_adr == HFU_OFF_CTRL);
	wire logic      wr_dhi  = wb_wr & (i_wb_adr == HFU_OFF_DAT_HI);
	wire logic      wr_dlo  = wb_wr & (i_wb_adr == HFU_OFF_DAT_LO);
	wire logic      idle    = (state_q == ST_IDLE);
	wire logic      launch  = wr_ctrl & idle;
	wire hfu_ctrl_t ctrl_w  = hfu_ctrl_t'((ctrl_q & ~wb_mask) | (i_wb_dat & wb_mask));

	// ----------------------------------------------------------------
	// Operand fetch from the active level bank.
	// ----------------------------------------------------------------
	wire logic [3:0]  a_idx = {ctrl_w.level, ctrl_w.first_register_select};   // RULE_21 RULE_23
	wire logic [3:0]  b_idx = {ctrl_w.level, ctrl_w.second_register_select};  // RULE_23
	wire logic [63:0] fa    = fpr_q[a_idx];
	wire logic [63:0] fb    = ctrl_w.stor ? {dhi_q, dlo_q} : fpr_q[b_idx];
	wire logic        is_short = ~ctrl_w.dbl;
	// Short operands see only the top 32 bits; long ones all 64.
	wire logic [55:0] fa_fr = is_short ? {fa[55:32], 32'h0} : fa[55:0];  // RULE_03 RULE_09
	wire logic [55:0] fb_fr = is_short ? {fb[55:32], 32'h0} : fb[55:0];  // RULE_03 RULE_09
	wire logic [6:0]  ca    = fa[62:56];
	wire logic [6:0]  cb    = fb[62:56];

	// ----------------------------------------------------------------
	// Add and subtract with alignment and a guard digit.
	// ----------------------------------------------------------------
	wire logic        a_ge   = (ca >= cb);
	wire logic [6:0]  cdiff  = a_ge ? (ca - cb) : (cb - ca);
	wire logic [8:0]  ash    = {cdiff, 2'b00};
	wire logic [63:0] keep   = is_short ? HFU_SHORT_KEEP : HFU_LONG_KEEP;  // RULE_10
	wire logic [63:0] wa     = ({4'h0, fa_fr, 4'h0} >> (a_ge ? 9'h0 : ash)) & keep;  // RULE_10
	wire logic [63:0] wb     = ({4'h0, fb_fr, 4'h0} >> (a_ge ? ash : 9'h0)) & keep;  // RULE_10
	wire logic [6:0]  ebig   = a_ge ? ca : cb;
	wire logic        sb_eff = fb[63] ^ (ctrl_w.op == OP_SUB);
	wire logic        effsub = fa[63] ^ sb_eff;
	wire logic        a_mge  = (wa >= wb);
	// Magnitudes are subtracted larger minus smaller; sign follows the larger.
	wire logic [63:0] sum    = ~effsub ? (wa + wb) : (a_mge ? (wa - wb) : (wb - wa));  // RULE_05
	wire logic        sum_sg = (effsub & ~a_mge) ? sb_eff : fa[63];                     // RULE_05

	// ----------------------------------------------------------------
	// Multiply: characteristics add and lose one bias.
	// ----------------------------------------------------------------
	wire logic [111:0] prod    = fa_fr * fb_fr;
	wire logic [8:0]   mul_exp = {2'b00, ca} + {2'b00, cb} - {2'b00, HFU_EXP_BIAS};  // RULE_04

	// ----------------------------------------------------------------
	// Integer conversions.
	// ----------------------------------------------------------------
	wire logic [31:0] ival = ctrl_w.int16 ? {{16{dhi_q[15]}}, dhi_q[15:0]} : dhi_q;  // RULE_12
	wire logic        ineg = ival[31];
	wire logic [31:0] imag = ineg ? (~ival + 32'h1) : ival;  // RULE_12
	// Exponent of the register value decides how many digits are integral.
	wire logic [8:0]  oexp  = {2'b00, ca} - {2'b00, HFU_EXP_BIAS};
	wire logic        o_sml = oexp[8] | (oexp == 9'h0);
	wire logic        o_ovf = ~o_sml & (oexp > 9'h008);
	wire logic [5:0]  osh   = 6'h38 - {oexp[3:0], 2'b00};
	wire logic [55:0] omagw = fa_fr >> osh;
	wire logic [31:0] omag  = (o_sml | o_ovf) ? 32'h0 : omagw[31:0];
	wire logic [31:0] oint  = fa[63] ? (~omag + 32'h1) : omag;  // RULE_14
	wire logic [31:0] oout  = ctrl_w.int16 ? {16'h0, oint[15:0]} : oint;

	// ----------------------------------------------------------------
	// Operation decode.
	// ----------------------------------------------------------------
	logic [63:0] n_w, l_val;
	logic [8:0]  n_exp;
	logic        n_sgn, n_norm, n_trunc, n_keep, go_norm;
	logic        l_wr, l_res, l_exc, bad_op;
	logic [31:0] l_rhi, l_rlo;

	// Each code either starts the datapath or finishes at once.
	always_comb begin
		n_w = 64'h0;
		n_exp = 9'h0;
		n_sgn = 1'b0;
		n_norm = 1'b0;
		n_trunc = 1'b0;
		n_keep = 1'b0;
		go_norm = 1'b0;
		l_wr = 1'b0;
		l_val = fa;
		l_res = 1'b0;
		l_rhi = 32'h0;
		l_rlo = 32'h0;
		l_exc = 1'b0;
		bad_op = 1'b0;
		unique case (ctrl_w.op)
			OP_ADD, OP_SUB: begin
				n_w = sum;
				n_exp = {2'b00, ebig};
				n_sgn = sum_sg;
				n_norm = effsub;  // RULE_16 RULE_17
				n_trunc = is_short;
				n_keep = is_short;  // RULE_06
				go_norm = 1'b1;
			end
			OP_MUL: begin
				n_w = {4'h0, prod[111:52]};  // RULE_07
				n_exp = mul_exp;
				n_sgn = fa[63] ^ fb[63];
				n_norm = 1'b1;  // RULE_16
				go_norm = 1'b1;
			end
			OP_LD, OP_PSET: begin
				l_wr = 1'b1;
				l_val = is_short ? {dhi_q, 32'h0} : {dhi_q, dlo_q};  // RULE_08 RULE_13
			end
			OP_LDCV: begin
				n_w = {4'h0, imag, 28'h0};  // RULE_12
				n_exp = HFU_CVT_EXP;
				n_sgn = ineg;
				n_norm = 1'b1;
				n_trunc = is_short;
				go_norm = 1'b1;
			end
			OP_ST, OP_PCOPY: begin
				l_res = 1'b1;
				l_rhi = fa[63:32];
				l_rlo = is_short ? 32'h0 : fa[31:0];
			end
			OP_STCV: begin
				l_res = 1'b1;
				l_rlo = oout;  // RULE_14
				l_exc = o_ovf;
			end
			OP_RRMV: begin
				l_wr = 1'b1;
				l_val = is_short ? {fb[63:32], fa[31:0]} : fb;  // RULE_06
			end
			default: bad_op = 1'b1;
		endcase
	end

	// ----------------------------------------------------------------
	// Trap checks, in priority order.
	// ----------------------------------------------------------------
	wire logic op_arith = (ctrl_w.op == OP_ADD) | (ctrl_w.op == OP_SUB) | (ctrl_w.op == OP_MUL);
	wire logic op_mem   = (ctrl_w.op == OP_LD) | (ctrl_w.op == OP_LDCV) |
	                      (ctrl_w.op == OP_ST) | (ctrl_w.op == OP_STCV);
	wire logic op_priv  = (ctrl_w.op == OP_PCOPY) | (ctrl_w.op == OP_PSET);
	wire logic t_spec   = ctrl_w.odd_addr & (op_mem | (op_arith & ctrl_w.stor));  // RULE_20
	wire logic t_priv   = ~t_spec & op_priv & ctrl_w.problem;                     // RULE_19
	wire logic t_inv    = ~t_spec & ~t_priv & (~ctrl_w.feature | bad_op);         // RULE_18
	wire logic trap_any = t_spec | t_priv | t_inv;
	wire logic launch_ok = launch & ~trap_any;

	// ----------------------------------------------------------------
	// Normalize steps and result packing.
	// ----------------------------------------------------------------
	wire logic carry  = |w_q[63:60];
	wire logic lead0  = (w_q[59:56] == 4'h0);
	wire logic w_nz   = |w_q[59:0];
	wire logic step_l = ~carry & norm_q & lead0 & w_nz;  // RULE_15
	wire logic fin    = (state_q == ST_FIN);

	wire logic [55:0] fr     = trunc_q ? {w_q[59:36], 32'h0} : w_q[59:4];  // RULE_10
	wire logic        unf    = exp_q[8];
	wire logic        ovf    = ~exp_q[8] & exp_q[7];
	wire logic [55:0] ovf_fr = trunc_q ? {24'hff_ffff, 32'h0} : 56'hff_ffff_ffff_ffff;
	wire logic [63:0] packed_v = ((fr == 56'h0) | unf) ? 64'h0 :                 // RULE_11
	                             ovf ? {sgn_q, HFU_CHAR_MAX, ovf_fr} :
	                             {sgn_q, exp_q[6:0], fr};                         // RULE_02 RULE_04
	wire logic [63:0] fin_val = keep_q ? {packed_v[63:32], fpr_q[dst_q][31:0]} : packed_v;  // RULE_06
	wire logic        fin_exc = ovf | (unf & (fr != 56'h0));

	// Register file write port.
	wire logic        rf_we  = (launch_ok & l_wr) | fin;
	wire logic [3:0]  rf_idx = fin ? dst_q : a_idx;
	wire logic [63:0] rf_val = fin ? fin_val : l_val;

	// Read data selection.
	wire logic [31:0] stat_w = {24'h0, trap_q, 2'b00, done_q, ~idle};
	wire logic [31:0] rd_mux = (i_wb_adr == HFU_OFF_CTRL)   ? ctrl_q :
	                           (i_wb_adr == HFU_OFF_DAT_HI) ? dhi_q :
	                           (i_wb_adr == HFU_OFF_DAT_LO) ? dlo_q :
	                           (i_wb_adr == HFU_OFF_RES_HI) ? rhi_q :
	                           (i_wb_adr == HFU_OFF_RES_LO) ? rlo_q :
	                           (i_wb_adr == HFU_OFF_STAT)   ? stat_w : 32'h0;

	// ----------------------------------------------------------------
	// Processes.
	// ----------------------------------------------------------------
	// Float registers carry no reset so their contents survive it.
	always_ff @(posedge i_ref_clk) begin
		if (rf_we) begin
			fpr_q[rf_idx] <= rf_val;  // RULE_01 RULE_22
		end
	end

	// Bus slave: one-cycle answer, ack drops after one cycle.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
			ctrl_q <= hfu_ctrl_t'(HFU_CTRL_RST);
			dhi_q <= HFU_DATA_RST;
			dlo_q <= HFU_DATA_RST;
		end else begin
			o_wb_ack <= wb_hit;
			o_wb_dat <= (wb_hit & ~i_wb_we) ? rd_mux : 32'h0;
			if (launch) begin
				ctrl_q <= ctrl_w;
			end
			if (wr_dhi) begin
				dhi_q <= (dhi_q & ~wb_mask) | (i_wb_dat & wb_mask);
			end
			if (wr_dlo) begin
				dlo_q <= (dlo_q & ~wb_mask) | (i_wb_dat & wb_mask);
			end
		end
	end

	// Sequencer and datapath registers.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
			w_q <= 64'h0;
			exp_q <= 9'h0;
			{sgn_q, norm_q, trunc_q, keep_q, done_q} <= 5'h0;
			trap_q <= '0;
			dst_q <= 4'h0;
			lo_snap_q <= 32'h0;
			rhi_q <= 32'h0;
			rlo_q <= 32'h0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (launch) begin
						trap_q <= '{fp_exc: l_exc & ~trap_any, inv_func: t_inv,
						            priv_viol: t_priv, spec_chk: t_spec};
						done_q <= ~(launch_ok & go_norm);
						dst_q <= a_idx;
						lo_snap_q <= fa[31:0];
						{w_q, exp_q, sgn_q} <= {n_w, n_exp, n_sgn};
						{norm_q, trunc_q, keep_q} <= {n_norm, n_trunc, n_keep};
						if (launch_ok & go_norm) begin
							state_q <= ST_NORM;
						end
						if (launch_ok & l_res) begin
							rhi_q <= l_rhi;
							rlo_q <= l_rlo;
						end
					end
				end
				ST_NORM: begin
					if (carry) begin
						w_q <= w_q >> 4;
						exp_q <= exp_q + 9'h1;
					end else if (step_l) begin
						w_q <= w_q << 4;           // RULE_15
						exp_q <= exp_q - 9'h1;     // RULE_15
					end else begin
						state_q <= ST_FIN;
					end
				end
				ST_FIN: begin
					trap_q.fp_exc <= trap_q.fp_exc | fin_exc;
					done_q <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	sequence s_left_step;
		(state_q == ST_NORM) && step_l;
	endsequence

	sequence s_short_ld;
		launch_ok && (ctrl_w.op == OP_LD) && is_short;
	endsequence

	a_spec_odd_addr: assert property (  // RULE_20
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(launch && t_spec) |=> (trap_q.spec_chk && done_q && state_q == ST_IDLE))
		else $error("odd address did not raise specification check");

	a_priv_problem: assert property (  // RULE_19
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(launch && !t_spec && op_priv && ctrl_w.problem) |=> (trap_q.priv_viol && !trap_q.inv_func))
		else $error("privileged op in problem state not trapped");

	a_inv_no_feature: assert property (  // RULE_18
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(launch && !ctrl_w.feature && !t_spec && !t_priv) |=> (trap_q.inv_func && state_q == ST_IDLE))
		else $error("missing feature did not trap as invalid function");

	a_true_zero_res: assert property (  // RULE_11
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(fin && (fr == 56'h0 || unf)) |=> (fpr_q[dst_q][63:32] == 32'h0))
		else $error("zero or underflow result is not true zero");

	a_short_lo_kept: assert property (  // RULE_06
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(fin && keep_q) |=> (fpr_q[dst_q][31:0] == lo_snap_q))
		else $error("short operation changed low register word");

	a_ld_clear_lo: assert property (  // RULE_08
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_short_ld |=> (fpr_q[dst_q][31:0] == 32'h0 && fpr_q[dst_q][63:32] == $past(dhi_q)))
		else $error("short load did not clear low register word");

	a_norm_digit: assert property (  // RULE_15
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_left_step |=> (exp_q == $past(exp_q) - 9'h1) && (w_q[63:4] == $past(w_q[59:0])))
		else $error("normalize step is not one hex digit");

	a_add_no_norm: assert property (  // RULE_17
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		((state_q == ST_NORM) && !norm_q && !carry) |=> (state_q == ST_FIN))
		else $error("true addition result was normalized");

	a_mul_normed: assert property (  // RULE_16
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(launch_ok && ctrl_w.op == OP_MUL) |=> (norm_q && state_q == ST_NORM) ##[1:20] fin)
		else $error("multiply did not normalize and finish");

endmodule

`default_nettype wire

// file: src/hfu_pkg.sv
// Purpose: Shared constants and types of the hex float unit.
// Assumes: 32-bit classic Wishbone register access at byte addresses.
// Notes:   Float words keep the sign in the most significant bit.

package hfu_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses).
	// ----------------------------------------------------------------
	localparam logic [7:0] HFU_OFF_CTRL   = 8'h00;
	localparam logic [7:0] HFU_OFF_DAT_HI = 8'h04;
	localparam logic [7:0] HFU_OFF_DAT_LO = 8'h08;
	localparam logic [7:0] HFU_OFF_RES_HI = 8'h0c;
	localparam logic [7:0] HFU_OFF_RES_LO = 8'h10;
	localparam logic [7:0] HFU_OFF_STAT   = 8'h14;

	// Reset values of the software visible registers.
	localparam logic [31:0] HFU_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] HFU_DATA_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Number format.
	// ----------------------------------------------------------------
	localparam logic [6:0]  HFU_EXP_BIAS   = 7'h40;
	localparam logic [6:0]  HFU_CHAR_MAX   = 7'h7f;
	localparam logic [8:0]  HFU_CVT_EXP    = 9'h048;
	localparam logic [63:0] HFU_SHORT_KEEP = 64'hffff_ffff_0000_0000;
	localparam logic [63:0] HFU_LONG_KEEP  = 64'hffff_ffff_ffff_ffff;
	localparam int          HFU_NLEVEL     = 4;
	localparam int          HFU_NREG       = 4;

	// Status bit positions.
	localparam int HFU_STAT_BUSY = 0;
	localparam int HFU_STAT_DONE = 1;
	localparam int HFU_STAT_TRAP = 4;

	// ----------------------------------------------------------------
	// Types.
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_ADD   = 4'h0,
		OP_SUB   = 4'h1,
		OP_MUL   = 4'h2,
		OP_LD    = 4'h3,
		OP_LDCV  = 4'h4,
		OP_ST    = 4'h5,
		OP_STCV  = 4'h6,
		OP_RRMV  = 4'h7,
		OP_PCOPY = 4'h8,
		OP_PSET  = 4'h9
	} hfu_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_NORM = 2'b01,
		ST_FIN  = 2'b10
	} hfu_state_t;

	// Control word written to start an operation.
	typedef struct packed {
		logic [15:0] unused;
		logic        stor;
		logic        int16;
		logic        odd_addr;
		logic        feature;
		logic        problem;
		logic        dbl;
		logic [1:0]  level;
		logic [1:0]  second_register_select;
		logic [1:0]  first_register_select;
		hfu_op_t     op;
	} hfu_ctrl_t;

	// Sticky trap causes of the last operation.
	typedef struct packed {
		logic fp_exc;
		logic inv_func;
		logic priv_viol;
		logic spec_chk;
	} hfu_trap_t;

endpackage

// file: bench/hfu_host.sv
// Purpose: Processor core model that issues classic Wishbone cycles.
// Assumes: One request at a time; the bench calls the cycle task.
// Notes:   Address and data lines change after release so stale values never match.

`timescale 1ns/1ps
`default_nettype none

module hfu_host
	import hfu_pkg::*;
(
	// Clock.
	input  wire logic        i_ref_clk,
	// Bus answer.
	input  wire logic [31:0] i_wb_dat,
	input  wire logic        i_wb_ack,
	// Bus request.
	output logic             o_wb_cyc,
	output logic             o_wb_stb,
	output logic             o_wb_we,
	output logic      [7:0]  o_wb_adr,
	output logic      [3:0]  o_wb_sel,
	output logic      [31:0] o_wb_dat
);
	// ----------------------------------------------------------------
	// Bus cycles.
	// ----------------------------------------------------------------

	// The bus is idle at time zero.
	initial begin
		o_wb_cyc = 1'b0;
		o_wb_stb = 1'b0;
		o_wb_we  = 1'b0;
		o_wb_adr = 8'h00;
		o_wb_sel = 4'h0;
		o_wb_dat = 32'h0000_0000;
	end

	// One request, held until ack is sampled high, then released.
	task automatic cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge i_ref_clk);
		o_wb_cyc <= 1'b1;
		o_wb_stb <= 1'b1;
		o_wb_we  <= we;
		o_wb_adr <= adr;
		o_wb_sel <= 4'hf;
		o_wb_dat <= wd;
		do @(posedge i_ref_clk); while (i_wb_ack !== 1'b1);
		rd = i_wb_dat;
		o_wb_cyc <= 1'b0;
		o_wb_stb <= 1'b0;
		o_wb_we  <= 1'b0;
		o_wb_adr <= ~adr;
		o_wb_dat <= ~wd;
	endtask

endmodule

`default_nettype wire

// file: bench/hfu_core_bench.sv
// Purpose: Self-checking bench of the hex float unit.
// Assumes: Register map and control word of the package.
// Notes:   A register model array holds the expected float registers.

`timescale 1ns/1ps
`default_nettype none

module hfu_core_bench
	import hfu_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and model state.
	// ----------------------------------------------------------------
	logic        i_ref_clk;
	logic        i_rst_n;
	logic        cyc, stb, we, ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, d, h;
	logic [63:0] mdl [16];
	int          errors, checks, cycles;
	localparam logic [4:0] NRM = 5'b00010;
	localparam logic [4:0] STO = 5'b10010;

	hfu_host u_host (.i_ref_clk(i_ref_clk), .i_wb_dat(rdat), .i_wb_ack(ack), .o_wb_cyc(cyc),
		.o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_sel(sel), .o_wb_dat(wdat));
	hfu_core u_hfu_core (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack));

	// Clock of 20 ns and a cycle limit that cuts a hang short.
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Tasks.
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] x;
		u_host.cycle(1'b1, a, v, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		u_host.cycle(1'b0, a, 32'h0000_0000, v);
	endtask

	// Control word: flags are stor, int16, odd address, feature, problem state.
	function automatic logic [31:0] cw(hfu_op_t op, logic [3:0] idx, logic dbl, logic [4:0] fl);
		hfu_ctrl_t c;
		c = '0;
		c.op = op;
		c.first_register_select = idx[1:0];
		c.level = idx[3:2];
		c.dbl = dbl;
		{c.stor, c.int16, c.odd_addr, c.feature, c.problem} = fl;
		return c;
	endfunction

	// Launch and poll status until done, with a bounded number of reads.
	task automatic run(input logic [31:0] c);
		logic [31:0] s;
		wr(HFU_OFF_CTRL, c);
		for (int i = 0; i < 40; i++) begin
			rd(HFU_OFF_STAT, s);
			if (s[HFU_STAT_DONE] === 1'b1) break;
		end
		chk("stat_done", 32'h1, {31'h0, s[HFU_STAT_DONE]});
	endtask

	task automatic ld(input logic [3:0] idx, input logic dbl, input logic [63:0] v);
		wr(HFU_OFF_DAT_HI, v[63:32]);
		wr(HFU_OFF_DAT_LO, v[31:0]);
		run(cw(OP_LD, idx, dbl, NRM));
	endtask

	task automatic st_chk(input logic [3:0] idx, input logic [63:0] e);
		logic [31:0] x;
		run(cw(OP_ST, idx, 1'b1, NRM));
		rd(HFU_OFF_RES_HI, x);
		chk("res_hi", e[63:32], x);
		rd(HFU_OFF_RES_LO, x);
		chk("res_lo", e[31:0], x);
	endtask

	// Short operation on register 9 with the second operand from storage.
	task automatic arith(input hfu_op_t op, input logic [31:0] a, input logic [31:0] b,
		input logic [63:0] e);
		mdl[9] = {a, $urandom};
		ld(4'h9, 1'b1, mdl[9]);
		wr(HFU_OFF_DAT_HI, b);
		wr(HFU_OFF_DAT_LO, $urandom);
		run(cw(op, 4'h9, 1'b0, STO));
		st_chk(4'h9, (op == OP_MUL) ? e : {e[63:32], mdl[9][31:0]});
	endtask

	task automatic cvt_in(input logic dbl, input logic [4:0] fl, input logic [31:0] v,
		input logic [63:0] e);
		wr(HFU_OFF_DAT_HI, v);
		run(cw(OP_LDCV, 4'h2, dbl, fl));
		st_chk(4'h2, e);
	endtask

	task automatic cvt_out(input logic [63:0] v, input logic [31:0] e);
		ld(4'h1, 1'b1, v);
		run(cw(OP_STCV, 4'h1, 1'b1, NRM));
		rd(HFU_OFF_RES_LO, d);
		chk("int_out", e, d);
	endtask

	// Register move from register 5 into register 7, both of level 1.
	task automatic rrmv(input logic dbl);
		hfu_ctrl_t c;
		c = hfu_ctrl_t'(cw(OP_RRMV, 4'h7, dbl, NRM));
		c.second_register_select = 2'b01;
		run(c);
		mdl[7] = dbl ? mdl[5] : {mdl[5][63:32], mdl[7][31:0]};
		st_chk(4'h7, mdl[7]);
	endtask

	// Trapped operation: status cause bits set and register 3 left alone.
	task automatic trap(input hfu_op_t op, input logic [4:0] fl, input logic [7:0] e);
		run(cw(op, 4'h3, 1'b1, fl));
		rd(HFU_OFF_STAT, d);
		chk("trap", {24'h0, e}, {24'h0, d[7:4], 4'h0});
		st_chk(4'h3, mdl[3]);
	endtask

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		i_rst_n = 1'b0;
		errors = 0;
		checks = 0;
		cycles = 0;
		void'($urandom(50259));
		repeat (6) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		rd(HFU_OFF_CTRL, d);
		chk("ctrl_rst", HFU_CTRL_RST, d);
		rd(HFU_OFF_STAT, d);
		chk("stat_rst", 32'h0000_0000, d);
		wr(8'h18, 32'hffff_ffff);
		rd(8'h18, d);
		chk("unmapped", 32'h0000_0000, d);
		$display("test bus done");
		for (int i = 0; i < 16; i++) begin
			mdl[i] = {$urandom, $urandom};
			ld(i[3:0], 1'b1, mdl[i]);
		end
		for (int i = 0; i < 16; i++) st_chk(i[3:0], mdl[i]);
		$display("test banks done");
		@(posedge i_ref_clk);
		i_rst_n <= 1'b0;
		repeat (6) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		st_chk(4'h5, mdl[5]);
		h = $urandom;
		ld(4'h6, 1'b0, {h, $urandom});
		st_chk(4'h6, {h, 32'h0000_0000});
		$display("test reset and short load done");
		arith(OP_ADD, 32'h4101_0000, 32'h4101_0000, {32'h4102_0000, 32'h0});
		arith(OP_SUB, 32'h4110_0000, 32'h410f_0000, {32'h4010_0000, 32'h0});
		arith(OP_ADD, 32'h4110_0000, 32'hc10f_0000, {32'h4010_0000, 32'h0});
		arith(OP_SUB, 32'h4110_0000, 32'h4010_0001, {32'h40ef_ffff, 32'h0});
		arith(OP_SUB, 32'hc123_4560, 32'hc123_4560, {32'h0000_0000, 32'h0});
		arith(OP_MUL, 32'h4110_0000, 32'h4110_0000, {32'h4110_0000, 32'h0});
		$display("test arithmetic done");
		cvt_in(1'b0, NRM, 32'h0000_0095, 64'h4295_0000_0000_0000);
		cvt_in(1'b0, NRM, 32'hffff_ffff, 64'hc110_0000_0000_0000);
		cvt_in(1'b0, 5'b01010, 32'h0000_ffff, 64'hc110_0000_0000_0000);
		cvt_in(1'b1, NRM, 32'h7fff_ffff, 64'h487f_ffff_ff00_0000);
		cvt_out(64'h4295_0000_0000_0000, 32'h0000_0095);
		cvt_out(64'hc295_0000_0000_0000, 32'hffff_ff6b);
		$display("test conversion done");
		mdl[3] = {$urandom, $urandom};
		ld(4'h3, 1'b1, mdl[3]);
		trap(OP_LD, 5'b00000, 8'h40);
		trap(OP_ADD, 5'b10000, 8'h40);
		trap(OP_PSET, 5'b00011, 8'h20);
		trap(OP_LD, 5'b00110, 8'h10);
		run(cw(OP_PCOPY, 4'h4, 1'b1, NRM));
		rd(HFU_OFF_RES_HI, d);
		chk("pcopy_hi", mdl[4][63:32], d);
		rd(HFU_OFF_RES_LO, d);
		chk("pcopy_lo", mdl[4][31:0], d);
		rrmv(1'b0);
		rrmv(1'b1);
		$display("test traps done");
		results();
	end

endmodule

`default_nettype wire
